// [core/fdcr_pkg.sv]
// constants for the floppy and dma configuration register bank
package fdcr_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LDN      = 8'h07;
	localparam logic [7:0] IDX_POWER    = 8'h22;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_DMA_SEL  = 8'h74;
	localparam logic [7:0] IDX_FMODE    = 8'hF0;
	localparam logic [7:0] IDX_FOPT     = 8'hF1;
	localparam logic [7:0] IDX_FTYPE    = 8'hF2;
	localparam logic [7:0] IDX_FRSV     = 8'hF3;
	localparam logic [7:0] IDX_DRV0     = 8'hF4;
	localparam logic [7:0] IDX_DRV1     = 8'hF5;
	// reset values
	localparam logic [7:0] RST_LDN      = 8'h00;
	localparam logic [2:0] RST_DMA_SEL  = 3'h4;
	localparam logic [7:0] RST_FMODE    = 8'h0E;
	localparam logic [7:0] RST_FOPT     = 8'h00;
	localparam logic [7:0] RST_FTYPE    = 8'hFF;
	localparam logic [7:0] RST_DRV      = 8'h00;
	// writable bits
	localparam logic [7:0] MASK_FMODE   = 8'hDF;
	localparam logic [7:0] MASK_FOPT    = 8'hCC;
	localparam logic [7:0] MASK_DRV     = 8'h5B;
	// field positions
	localparam int DMA_NONE_BIT = 2;
	localparam int FM_ENH       = 0;
	localparam int FM_NOBURST   = 1;
	localparam int FM_IF_LO     = 2;
	localparam int FM_SWAP      = 4;
	localparam int FM_PUSHPULL  = 6;
	localparam int FM_TRIST     = 7;
	localparam int FO_DENS_LO   = 2;
	localparam int FO_BOOT_LO   = 6;
	localparam int FO_BOOT_NONE = 7;
	localparam int FT_A_LO      = 0;
	localparam int FT_B_LO      = 2;
	localparam int DRV_TYPE_LO  = 0;
	localparam int DRV_RATE_LO  = 3;
	localparam int DRV_PTS      = 6;
	// codes
	localparam logic [1:0] DENS_FORCE1 = 2'h2;
	localparam logic [1:0] DENS_FORCE0 = 2'h3;
	localparam logic [2:0] ECR_FIFO    = 3'h2;
	localparam logic [2:0] ECR_ECP     = 3'h3;
	localparam logic [2:0] ECR_TEST    = 3'h6;
	localparam logic [7:0] LDN_FDC     = 8'h00;
	localparam logic [7:0] LDN_PP      = 8'h03;
	localparam logic [7:0] LDN_SP1     = 8'h04;
	localparam logic [7:0] LDN_SP2     = 8'h05;
	// function slots
	localparam int NUM_DEV = 4;
	localparam int DEV_FDC = 0;
	localparam int DEV_PP  = 1;
	localparam int DEV_SP1 = 2;
	localparam int DEV_SP2 = 3;
	localparam int NUM_CH  = 4;
	localparam int NUM_PIN = 5;
endpackage

// [core/fdcr_config_regs.sv]
// configuration bank: dma select, output gating, floppy vendor registers
`timescale 1ns/1ps
// Summary of operation
// - dma select low three bits: 0..3 pick channel, 4..7 no dma
// - channel active only with select 0..3 and the function's dma enable
// - parallel ecp dma also needs the ecp control dma enable bit
// - request pins not used by any function float
// - a function's own disable bit disables its irq and dack
// - floppy gate off or powerdown: irq, dack float, requests ignored
// - serial irq floats while its modem control aux bit is zero
// - parallel irq floats in standard modes while irq gate is zero
// - ecp: dma by dma enable; modes 010,011,110 irq always on
// - vendor registers reset only on hard reset, never soft reset
// - mode bit 0 picks normal or enhanced floppy mode
// - mode bit 1: zero burst dma, one non-burst (default)
// - mode bits 3:2 pick interface personality, 11 default
// - mode bit 4 swaps drive and motor selects 0 and 1
// - mode bit 6: zero open drain, one push-pull floppy outputs
// - mode bit 7 floats floppy outputs; parallel-routed pins unaffected
// - option bits 3:2 density: normal, forced one, forced zero
// - option bits 7:6 boot drive 0, 1, or none
// - type register holds drive types A and B, resets to all ones
// - index F3 is read-only and reads zero
// - per-drive register: type, rate table, precomp disable; others zero
// - second drive register mirrors first in layout and default
// - activate and power bits are one; changing either changes both
module fdcr_config_regs
	import fdcr_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        soft_rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	input  wire logic [3:0]  base_ok_i,
	input  wire logic        floppy_dma_gate_i,
	input  wire logic        fdc_pwrdn_i,
	input  wire logic        pp_ecp_mode_i,
	input  wire logic [2:0]  ecr_mode_i,
	input  wire logic        ecp_dma_gate_i,
	input  wire logic        parallel_irq_gate_i,
	input  wire logic [1:0]  uart_aux_irq_gate_i,
	input  wire logic        uart2_dma_gate_i,
	input  wire logic [3:0]  dev_drq_i,
	input  wire logic [3:0]  dack_n_i,
	output logic [3:0]       dev_dack_o,
	output logic [3:0]       dma_request_pins_o,
	output logic [3:0]       dma_request_pins_oe_o,
	output logic [3:0]       irq_oe_o,
	input  wire logic [1:0]  core_drive_sel_i,
	input  wire logic [1:0]  core_motor_i,
	input  wire logic        core_density_i,
	output logic [4:0]       fpin_o,
	output logic [4:0]       fpin_oe_o,
	output logic             enhanced_mode_o,
	output logic             burst_en_o,
	output logic [1:0]       if_mode_o,
	output logic [1:0]       boot_drive_o,
	output logic             boot_valid_o,
	output logic [1:0]       drive_a_type_o,
	output logic [1:0]       drive_b_type_o,
	output logic [1:0]       drive0_type_sel_o,
	output logic [1:0]       drive1_type_sel_o,
	output logic [1:0]       drive0_rate_table_sel_o,
	output logic [1:0]       drive1_rate_table_sel_o,
	output logic             drive0_precomp_disable_o,
	output logic             drive1_precomp_disable_o
);
	import fdcr_pkg::*;

	logic [7:0] ldn_q;
	logic [3:0] dev_on_q;
	logic [2:0] dma_sel_q [NUM_DEV];
	logic [7:0] fmode_q;
	logic [7:0] fopt_q;
	logic [7:0] ftype_q;
	logic [7:0] drv_q [2];
	logic       wr_q;
	logic       rd_q;
	logic       rd_done_q;
	logic       ok_q;
	logic [7:0] idx_q;
	logic [31:0] hrdata_q;
	logic [7:0] rdata_d;
	logic       accept;
	logic       cur_ok;
	logic [1:0] cur_slot;
	logic       cur_fdc;
	logic [3:0] act;
	logic [3:0] irq_en;
	logic [3:0] fn_en;
	logic [3:0] drq_oe_d;
	logic [3:0] drq_d;
	logic       pp_irq_on;
	logic [1:0] dsel_sw;
	logic [1:0] mot_sw;
	logic       dens_lvl;
	logic [4:0] pin_lvl;

	// slot of the selected logical device, unused numbers are not mapped
	always_comb begin
		cur_ok = 1'b1;
		cur_slot = 2'(DEV_FDC);
		case (ldn_q)
			LDN_FDC: cur_slot = 2'(DEV_FDC);
			LDN_PP:  cur_slot = 2'(DEV_PP);
			LDN_SP1: cur_slot = 2'(DEV_SP1);
			LDN_SP2: cur_slot = 2'(DEV_SP2);
			default: cur_ok = 1'b0;
		endcase
	end
	assign cur_fdc = (ldn_q == LDN_FDC);

	// ahb-lite slave: writes zero wait, reads one wait state
	assign accept = hsel_i & htrans_i[1] & hready_i;
	assign hreadyout_o = ~(rd_q & ~rd_done_q);
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ok_q <= 1'b0;
			idx_q <= IDX_LDN;
		end else if (hready_i) begin
			wr_q <= accept & hwrite_i;
			rd_q <= accept & ~hwrite_i;
			ok_q <= (haddr_i[31:10] == 22'h000000)
				& (haddr_i[1:0] == 2'h0);
			idx_q <= haddr_i[9:2];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_done_q <= 1'b0;
			hrdata_q <= 32'h00000000;
		end else begin
			rd_done_q <= rd_q & ~rd_done_q;
			if (rd_q & ~rd_done_q)
				hrdata_q <= {24'h000000, ok_q ? rdata_d : 8'h00};
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		case (idx_q)
			IDX_LDN: rdata_d = ldn_q;
			IDX_POWER: rdata_d = {4'h0, dev_on_q};
			IDX_ACTIVATE:
				if (cur_ok) rdata_d = {7'h00, dev_on_q[cur_slot]};
			IDX_DMA_SEL:
				if (cur_ok) rdata_d = {5'h00, dma_sel_q[cur_slot]};
			IDX_FMODE: if (cur_fdc) rdata_d = fmode_q;
			IDX_FOPT:  if (cur_fdc) rdata_d = fopt_q;
			IDX_FTYPE: if (cur_fdc) rdata_d = ftype_q;
			IDX_FRSV:  rdata_d = 8'h00;
			IDX_DRV0:  if (cur_fdc) rdata_d = drv_q[0];
			IDX_DRV1:  if (cur_fdc) rdata_d = drv_q[1];
			default:   rdata_d = 8'h00;
		endcase
	end

	// only the hard reset rst_i restores defaults; soft_rst_i is ignored
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			ldn_q <= RST_LDN;
		else if (wr_q & ok_q & (idx_q == IDX_LDN))
			ldn_q <= hwdata_i[7:0];
	end

	// one flop per function serves both the activate and power views
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dev_on_q <= 4'h0;
		end else if (wr_q & ok_q) begin
			if (idx_q == IDX_POWER)
				dev_on_q <= hwdata_i[3:0];
			else if ((idx_q == IDX_ACTIVATE) & cur_ok)
				dev_on_q[cur_slot] <= hwdata_i[0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_DEV; i++)
				dma_sel_q[i] <= RST_DMA_SEL;
		end else if (wr_q & ok_q & cur_ok & (idx_q == IDX_DMA_SEL)) begin
			dma_sel_q[cur_slot] <= hwdata_i[2:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fmode_q <= RST_FMODE;
			fopt_q <= RST_FOPT;
			ftype_q <= RST_FTYPE;
			drv_q[0] <= RST_DRV;
			drv_q[1] <= RST_DRV;
		end else if (wr_q & ok_q & cur_fdc) begin
			case (idx_q)
				IDX_FMODE: fmode_q <= hwdata_i[7:0] & MASK_FMODE;
				IDX_FOPT:  fopt_q <= hwdata_i[7:0] & MASK_FOPT;
				IDX_FTYPE: ftype_q <= hwdata_i[7:0];
				IDX_DRV0:  drv_q[0] <= hwdata_i[7:0] & MASK_DRV;
				IDX_DRV1:  drv_q[1] <= hwdata_i[7:0] & MASK_DRV;
				default: ;
			endcase
		end
	end

	// per-function enables: config activate, valid base, own gate bits
	assign fn_en = dev_on_q & base_ok_i;
	assign pp_irq_on = pp_ecp_mode_i & ((ecr_mode_i == ECR_FIFO)
		| (ecr_mode_i == ECR_ECP) | (ecr_mode_i == ECR_TEST));

	always_comb begin
		irq_en[DEV_FDC] = fn_en[DEV_FDC] & floppy_dma_gate_i
			& ~fdc_pwrdn_i;
		irq_en[DEV_PP] = fn_en[DEV_PP]
			& (pp_irq_on | parallel_irq_gate_i);
		irq_en[DEV_SP1] = fn_en[DEV_SP1] & uart_aux_irq_gate_i[0];
		irq_en[DEV_SP2] = fn_en[DEV_SP2] & uart_aux_irq_gate_i[1];
		act[DEV_FDC] = irq_en[DEV_FDC]
			& ~dma_sel_q[DEV_FDC][DMA_NONE_BIT];
		act[DEV_PP] = fn_en[DEV_PP] & pp_ecp_mode_i & ecp_dma_gate_i
			& ~dma_sel_q[DEV_PP][DMA_NONE_BIT];
		act[DEV_SP1] = 1'b0;
		act[DEV_SP2] = fn_en[DEV_SP2] & uart2_dma_gate_i
			& ~dma_sel_q[DEV_SP2][DMA_NONE_BIT];
	end

	// a request pin is driven only while some active function owns it
	always_comb begin
		drq_oe_d = 4'h0;
		drq_d = 4'h0;
		for (int d = 0; d < NUM_DEV; d++) begin
			if (act[d]) begin
				drq_oe_d[dma_sel_q[d][1:0]] = 1'b1;
				if (dev_drq_i[d])
					drq_d[dma_sel_q[d][1:0]] = 1'b1;
			end
		end
	end

	always_comb begin
		for (int d = 0; d < NUM_DEV; d++)
			dev_dack_o[d] = act[d] & ~dack_n_i[dma_sel_q[d][1:0]];
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dma_request_pins_o <= 4'h0;
			dma_request_pins_oe_o <= 4'h0;
			irq_oe_o <= 4'h0;
		end else begin
			dma_request_pins_o <= drq_d;
			dma_request_pins_oe_o <= drq_oe_d;
			irq_oe_o <= irq_en;
		end
	end

	// floppy pins: selects swapped on request, select and motor pins active low, density not inverted
	assign dsel_sw = fmode_q[FM_SWAP] ? {core_drive_sel_i[0],
		core_drive_sel_i[1]} : core_drive_sel_i;
	assign mot_sw = fmode_q[FM_SWAP] ? {core_motor_i[0],
		core_motor_i[1]} : core_motor_i;

	always_comb begin
		case (fopt_q[FO_DENS_LO +: 2])
			DENS_FORCE1: dens_lvl = 1'b1;
			DENS_FORCE0: dens_lvl = 1'b0;
			default:     dens_lvl = core_density_i;
		endcase
		pin_lvl = {dens_lvl, ~mot_sw, ~dsel_sw};
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fpin_o <= 5'h00;
			fpin_oe_o <= 5'h00;
		end else if (fmode_q[FM_TRIST]) begin
			fpin_o <= 5'h00;
			fpin_oe_o <= 5'h00;
		end else if (fmode_q[FM_PUSHPULL]) begin
			fpin_o <= pin_lvl;
			fpin_oe_o <= 5'h1F;
		end else begin
			fpin_o <= 5'h00;
			fpin_oe_o <= ~pin_lvl;
		end
	end

	assign enhanced_mode_o = fmode_q[FM_ENH];
	assign burst_en_o = ~fmode_q[FM_NOBURST];
	assign if_mode_o = fmode_q[FM_IF_LO +: 2];
	assign boot_drive_o = fopt_q[FO_BOOT_LO +: 2];
	assign boot_valid_o = ~fopt_q[FO_BOOT_NONE];
	assign drive_a_type_o = ftype_q[FT_A_LO +: 2];
	assign drive_b_type_o = ftype_q[FT_B_LO +: 2];
	assign drive0_type_sel_o = drv_q[0][DRV_TYPE_LO +: 2];
	assign drive1_type_sel_o = drv_q[1][DRV_TYPE_LO +: 2];
	assign drive0_rate_table_sel_o = drv_q[0][DRV_RATE_LO +: 2];
	assign drive1_rate_table_sel_o = drv_q[1][DRV_RATE_LO +: 2];
	assign drive0_precomp_disable_o = drv_q[0][DRV_PTS];
	assign drive1_precomp_disable_o = drv_q[1][DRV_PTS];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rd_rsv;
		rd_q && !rd_done_q && ok_q && (idx_q == IDX_FRSV);
	endsequence
	sequence s_wr_drv0;
		wr_q && ok_q && cur_fdc && (idx_q == IDX_DRV0);
	endsequence

	a_dma_none_idle: assert property (
		dma_sel_q[DEV_FDC][DMA_NONE_BIT] |-> !act[DEV_FDC])
		else $error("floppy dma active with no channel");
	a_ecp_dma_need: assert property (
		!(pp_ecp_mode_i && ecp_dma_gate_i) |-> !act[DEV_PP])
		else $error("parallel dma active outside ecp enable");
	a_drq_float: assert property (
		(act == 4'h0) |=> (dma_request_pins_oe_o == 4'h0))
		else $error("request pin driven while unused");
	a_fdc_gate_off: assert property (
		(!floppy_dma_gate_i || fdc_pwrdn_i) |-> !dev_dack_o[DEV_FDC]
		##1 !irq_oe_o[DEV_FDC])
		else $error("floppy irq or dack not floated");
	a_uart_aux_off: assert property (
		!uart_aux_irq_gate_i[0] |=> !irq_oe_o[DEV_SP1])
		else $error("serial irq driven with aux bit low");
	a_ecp_irq_on: assert property (
		fn_en[DEV_PP] && pp_ecp_mode_i && (ecr_mode_i == ECR_ECP)
		|=> irq_oe_o[DEV_PP])
		else $error("ecp irq not forced on");
	a_swap_pins: assert property (
		fmode_q[FM_SWAP] && fmode_q[FM_PUSHPULL] && !fmode_q[FM_TRIST]
		&& (core_drive_sel_i == 2'h1) |=> (fpin_o[1:0] == 2'h1))
		else $error("drive selects not swapped");
	a_tristate_pins: assert property (
		fmode_q[FM_TRIST] |=> (fpin_oe_o == 5'h00))
		else $error("floppy pins driven while tristated");
	a_rsv_read_zero: assert property (
		s_rd_rsv |=> hreadyout_o && (hrdata_o == 32'h00000000))
		else $error("reserved index read not zero");
	a_drv_mask: assert property (
		s_wr_drv0 |=> (drv_q[0] == ($past(hwdata_i[7:0]) & MASK_DRV)))
		else $error("per-drive write mask wrong");
	a_power_link: assert property (
		wr_q && ok_q && (idx_q == IDX_POWER) |=>
		(dev_on_q == $past(hwdata_i[3:0])))
		else $error("power write not mirrored");
	a_pp_irq_gate: assert property (
		!pp_ecp_mode_i && !parallel_irq_gate_i |=> !irq_oe_o[DEV_PP])
		else $error("parallel irq driven with gate low");
	a_base_gate: assert property (
		!base_ok_i[DEV_FDC] |-> !dev_dack_o[DEV_FDC] ##1 !irq_oe_o[DEV_FDC])
		else $error("floppy irq or dack on with invalid base");
	a_dens_force: assert property (
		(fopt_q[FO_DENS_LO +: 2] == DENS_FORCE1) && fmode_q[FM_PUSHPULL]
		&& !fmode_q[FM_TRIST] |=> fpin_o[4])
		else $error("density not forced high");

endmodule // fdcr_config_regs

// [testbench/fdcr_host_dma.sv]
// host dma controller model: acknowledges each driven request
`timescale 1ns/1ps
module fdcr_host_dma #(
	parameter int ACK_DLY = 2
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] req_i,
	input  wire logic [3:0] req_oe_i,
	input  wire logic       stuck_i,
	output logic [3:0]      dack_n_o
);
	logic [3:0]           line;
	logic [4*ACK_DLY-1:0] pipe_q;
	// released request lines are pulled low on the board
	assign line = req_i & req_oe_i;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			pipe_q <= '0;
		else
			pipe_q <= {pipe_q[4*ACK_DLY-5:0], line};
	end
	// a faulty host may hold every acknowledge low
	assign dack_n_o = stuck_i ? 4'h0 : ~(pipe_q[4*ACK_DLY-1 -: 4] & line);
endmodule // fdcr_host_dma

// [testbench/fdcr_config_regs_test.sv]
// self-checking bench for the floppy and dma configuration bank
`timescale 1ns/1ps
module fdcr_config_regs_test;
	import fdcr_pkg::*;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0, stuck = 1'b0;
	logic hsel_i = 1'b0, hwrite_i = 1'b0, hready_i, core_density_i = 1'b1;
	logic floppy_dma_gate_i = 1'b0, fdc_pwrdn_i = 1'b0, pp_ecp_mode_i = 1'b0;
	logic ecp_dma_gate_i = 1'b0, parallel_irq_gate_i = 1'b0;
	logic uart2_dma_gate_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0, uart_aux_irq_gate_i = 2'h0;
	logic [1:0]  core_drive_sel_i = 2'h1, core_motor_i = 2'h2;
	logic [2:0]  hsize_i = 3'h2, ecr_mode_i = 3'h0;
	logic [3:0]  base_ok_i = 4'hF, dev_drq_i = 4'hB, dack_n_i;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	logic        hreadyout_o, hresp_o, enhanced_mode_o, burst_en_o;
	logic        boot_valid_o, drive0_precomp_disable_o;
	logic        drive1_precomp_disable_o;
	logic [1:0]  if_mode_o, boot_drive_o, drive_a_type_o, drive_b_type_o;
	logic [1:0]  drive0_type_sel_o, drive1_type_sel_o;
	logic [1:0]  drive0_rate_table_sel_o, drive1_rate_table_sel_o;
	logic [3:0]  dev_dack_o, dma_request_pins_o, dma_request_pins_oe_o;
	logic [3:0]  irq_oe_o;
	logic [4:0]  fpin_o, fpin_oe_o;
	int          n_errors = 0, checks = 0;
	logic [7:0]  idx [7] = '{IDX_DMA_SEL, IDX_FMODE, IDX_FOPT, IDX_FTYPE,
		IDX_FRSV, IDX_DRV0, IDX_DRV1};
	logic [7:0]  dfl [7] = '{8'h04, 8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk [7] = '{8'h07, 8'hDF, 8'hCC, 8'hFF, 8'h00, 8'h5B, 8'h5B};
	logic [7:0]  fm_v [6] = '{8'h4E, 8'h5E, 8'h0E, 8'hCE, 8'h41, 8'h55};
	logic [4:0]  fm_oe [6] = '{5'h1F, 5'h1F, 5'h09, 5'h00, 5'h1F, 5'h1F};
	logic [4:0]  fm_lv [6] = '{5'h16, 5'h19, 5'h16, 5'h16, 5'h16, 5'h19};

	assign hready_i = hreadyout_o;

	fdcr_config_regs dut (
		.ref_clk_i, .rst_i, .soft_rst_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
		.hrdata_o, .base_ok_i, .floppy_dma_gate_i, .fdc_pwrdn_i,
		.pp_ecp_mode_i, .ecr_mode_i, .ecp_dma_gate_i, .parallel_irq_gate_i,
		.uart_aux_irq_gate_i, .uart2_dma_gate_i, .dev_drq_i, .dack_n_i,
		.dev_dack_o, .dma_request_pins_o, .dma_request_pins_oe_o, .irq_oe_o,
		.core_drive_sel_i, .core_motor_i, .core_density_i, .fpin_o,
		.fpin_oe_o, .enhanced_mode_o, .burst_en_o, .if_mode_o, .boot_drive_o,
		.boot_valid_o, .drive_a_type_o, .drive_b_type_o, .drive0_type_sel_o,
		.drive1_type_sel_o, .drive0_rate_table_sel_o,
		.drive1_rate_table_sel_o, .drive0_precomp_disable_o,
		.drive1_precomp_disable_o
	);

	fdcr_host_dma #(.ACK_DLY(3)) host (
		.ref_clk_i, .rst_i, .req_i(dma_request_pins_o),
		.req_oe_i(dma_request_pins_oe_o), .stuck_i(stuck),
		.dack_n_o(dack_n_i)
	);

	initial forever #2 ref_clk_i = ~ref_clk_i;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one single-word transfer; ready is looked at before the edge it meets
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge ref_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {22'h0, a, 2'h0};
		do @(negedge ref_clk_i); while (hreadyout_o !== 1'b1);
		@(posedge ref_clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		do @(negedge ref_clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
		@(posedge ref_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask

	task automatic all_regs(input bit d);
		for (int i = 0; i < 7; i++) rc(idx[i], d ? dfl[i] : msk[i]);
	endtask

	task automatic settle;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask

	task automatic hard_reset;
		rst_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
	endtask

	task automatic finish_test;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test;
	end

	initial begin
		logic p;
		hard_reset;
		all_regs(1'b1);
		for (int i = 0; i < 7; i++) wr(idx[i], 8'hFF);
		wr(8'h50, 8'hFF);
		rc(8'h50, 8'h00);
		all_regs(1'b0);
		@(posedge ref_clk_i);
		soft_rst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		soft_rst_i <= 1'b0;
		all_regs(1'b0);
		hard_reset;
		all_regs(1'b1);
		wr(IDX_ACTIVATE, 8'h01);
		rc(IDX_POWER, 8'h01);
		wr(IDX_POWER, 8'h00);
		rc(IDX_ACTIVATE, 8'h00);
		wr(IDX_POWER, 8'h0F);
		for (int i = 0; i < 6; i++) begin
			wr(IDX_FMODE, fm_v[i]);
			settle;
			chk(enhanced_mode_o, fm_v[i][0]);
			chk(burst_en_o, !fm_v[i][1]);
			chk(if_mode_o, fm_v[i][3:2]);
			chk(fpin_oe_o, fm_oe[i]);
			if (fm_oe[i] == 5'h1F) chk(fpin_o, fm_lv[i]);
		end
		wr(IDX_FMODE, 8'h4E);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk_i);
			core_density_i <= i[0];
			wr(IDX_FOPT, {i[2:1], 2'h0, i[2:1], 2'h0});
			settle;
			chk(fpin_o[4], i[2] ? !i[1] : i[0]);
			chk(boot_drive_o, i[2:1]);
			chk(boot_valid_o, !i[2]);
		end
		wr(IDX_FTYPE, 8'h1B);
		wr(IDX_DRV0, 8'h5A);
		wr(IDX_DRV1, 8'h09);
		settle;
		chk({drive_b_type_o, drive_a_type_o}, 4'hB);
		chk({drive0_precomp_disable_o, drive0_rate_table_sel_o,
			drive0_type_sel_o}, 5'h1E);
		chk({drive1_precomp_disable_o, drive1_rate_table_sel_o,
			drive1_type_sel_o}, 5'h05);
		@(posedge ref_clk_i);
		floppy_dma_gate_i <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			wr(IDX_DMA_SEL, s[7:0]);
			settle;
			chk(dma_request_pins_oe_o, s < 4 ? 4'h1 << s : 4'h0);
		end
		wr(IDX_DMA_SEL, 8'h02);
		settle;
		settle;
		chk(dma_request_pins_o & dma_request_pins_oe_o, 4'h4);
		chk(dev_dack_o, 4'h1);
		@(posedge ref_clk_i);
		floppy_dma_gate_i <= 1'b0;
		stuck <= 1'b1;
		settle;
		chk({dma_request_pins_oe_o, dev_dack_o}, 8'h00);
		@(posedge ref_clk_i);
		floppy_dma_gate_i <= 1'b1;
		fdc_pwrdn_i <= 1'b1;
		settle;
		chk({dma_request_pins_oe_o, dev_dack_o}, 8'h00);
		@(posedge ref_clk_i);
		fdc_pwrdn_i <= 1'b0;
		stuck <= 1'b0;
		pp_ecp_mode_i <= 1'b1;
		wr(IDX_LDN, LDN_PP);
		wr(IDX_DMA_SEL, 8'h01);
		settle;
		chk(dma_request_pins_oe_o, 4'h4);
		@(posedge ref_clk_i);
		ecp_dma_gate_i <= 1'b1;
		uart2_dma_gate_i <= 1'b1;
		wr(IDX_LDN, LDN_SP2);
		wr(IDX_DMA_SEL, 8'h03);
		wr(IDX_LDN, LDN_SP1);
		wr(IDX_DMA_SEL, 8'h00);
		settle;
		chk(dma_request_pins_o & dma_request_pins_oe_o, 4'hE);
		chk(dma_request_pins_oe_o, 4'hE);
		for (int i = 0; i < 32; i++) begin
			@(posedge ref_clk_i);
			pp_ecp_mode_i <= i[4];
			parallel_irq_gate_i <= i[3];
			ecr_mode_i <= i[2:0];
			uart_aux_irq_gate_i <= i[1:0];
			floppy_dma_gate_i <= i[0];
			fdc_pwrdn_i <= i[1];
			settle;
			p = i[3] || (i[4] && (i[2:0] inside {3'h2, 3'h3, 3'h6}));
			chk(irq_oe_o[0], i[0] && !i[1]);
			chk(irq_oe_o[1], p);
			chk(irq_oe_o[3:2], i[1:0]);
		end
		@(posedge ref_clk_i);
		fdc_pwrdn_i <= 1'b0;
		floppy_dma_gate_i <= 1'b1;
		settle;
		chk({irq_oe_o[0], dma_request_pins_oe_o[2]}, 2'h3);
		@(posedge ref_clk_i);
		base_ok_i <= 4'hE;
		settle;
		chk({irq_oe_o[0], dma_request_pins_oe_o[2], dev_dack_o[0]}, 3'h0);
		finish_test;
	end
endmodule // fdcr_config_regs_test
